// ===== sim/romc_host_model.sv
// Host-side model: paired command/response exchanges
`timescale 1ns/1ps
`default_nettype none
module romc_host_model (
	input  wire logic       ref_clk,    // Module clock
	input  wire logic       rsp_valid,  // Device response strobe
	input  wire logic [1:0] rsp_status, // Device response status
	output logic            cmd_valid,  // Command strobe
	output logic [3:0]      cmd_code    // Command code
);
	int   unsolicited;
	logic waiting;

	initial begin
		cmd_valid   = 1'b0;
		cmd_code    = 4'ha;
		unsolicited = 0;
		waiting     = 1'b0;
	end

	// A response with no command outstanding breaks pairing; seen here before the edge updates it
	always @(posedge ref_clk) begin
		if (rsp_valid === 1'b1) begin
			if (waiting) begin
				waiting = 1'b0;
			end else begin
				unsolicited = unsolicited + 1;
			end
		end
	end

	// One strobe cycle per command, then a bounded wait for its answer
	task automatic send(input logic [3:0] code, output logic got, output logic [1:0] st);
		int n;
		got = 1'b0;
		st  = 2'h3;
		@(negedge ref_clk);
		cmd_code  = code;
		cmd_valid = 1'b1;
		waiting   = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		// Code lines are not left showing the last command
		cmd_code  = ~code;
		for (n = 0; n < 4 && !got; n++) begin
			if (rsp_valid === 1'b1) begin
				got = 1'b1;
				st  = rsp_status;
			end else begin
				@(negedge ref_clk);
			end
		end
		// An answered command is retired at the edge that ends its response
		if (!got) begin
			waiting = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ===== sim/romc_mode_ctrl_test.sv
// Self-checking testbench for the operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module romc_mode_ctrl_test;
	import romc_pkg::*;
	logic       ref_clk;
	logic       resetn;
	logic       external_reset_pin_n;
	logic       wake_pin;
	logic [3:0] gpio_in;
	logic       cmd_valid;
	logic [3:0] cmd_code;
	logic       rsp_valid;
	logic [1:0] rsp_status;
	romc_mode_t mode;
	romc_link_t link_state;
	logic       bootstrap_active;
	logic       read_enable;
	logic       host_if_enable;
	logic       idle_low_latency;
	logic       report_valid;
	int         miscompares;
	int         checked;

	romc_mode_ctrl i_romc_mode_ctrl (.ref_clk(ref_clk), .resetn(resetn),
		.external_reset_pin_n(external_reset_pin_n), .wake_pin(wake_pin), .gpio_in(gpio_in),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
		.mode(mode), .link_state(link_state), .bootstrap_active(bootstrap_active),
		.read_enable(read_enable), .host_if_enable(host_if_enable),
		.idle_low_latency(idle_low_latency), .report_valid(report_valid));

	romc_host_model i_romc_host_model (.ref_clk(ref_clk), .rsp_valid(rsp_valid),
		.rsp_status(rsp_status), .cmd_valid(cmd_valid), .cmd_code(cmd_code));

	always #25 ref_clk = ~ref_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wait_mode(input romc_mode_t m, input int bound, output int n);
		n = 0;
		while (mode !== m && n < bound) begin
			@(negedge ref_clk);
			n++;
		end
		if (mode !== m) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, mode, m);
			end_sim();
		end
	endtask

	// Mode plus the enables that follow from it
	task automatic chk_mode(input romc_mode_t m);
		check({13'h0, mode}, {13'h0, m});
		check({15'h0, read_enable}, {15'h0, m == ROMC_ACTIVE});
		check({15'h0, host_if_enable}, {15'h0, m == ROMC_ACTIVE || m == ROMC_IDLE});
		check({15'h0, bootstrap_active}, {15'h0, m == ROMC_STARTUP});
	endtask

	task automatic cmd(input logic [3:0] code, input logic [1:0] exp);
		logic       got;
		logic [1:0] st;
		i_romc_host_model.send(code, got, st);
		check({15'h0, got}, 16'h1);
		check({14'h0, st}, {14'h0, exp});
	endtask

	// Command sent where the port is closed must go unanswered
	task automatic cmd_ignored(input logic [3:0] code);
		logic       got;
		logic [1:0] st;
		i_romc_host_model.send(code, got, st);
		check({15'h0, got}, 16'h0);
	endtask

	task automatic s_startup();
		int n;
		repeat (20) @(negedge ref_clk);
		chk_mode(ROMC_STARTUP); // Held while wake high
		cmd_ignored(ROMC_CMD_ACTIVATE);
		wake_pin = 1'b0;
		wait_mode(ROMC_IDLE, 10, n);
		chk_mode(ROMC_IDLE);
		check({14'h0, link_state}, {14'h0, ROMC_LINK_CONFIG});
	endtask

	task automatic s_latency();
		int n;
		cmd(ROMC_CMD_ACTIVATE, ROMC_RSP_OK);
		wait_mode(ROMC_ACTIVE, ROMC_WAKE_STD_CYC + 10, n);
		check({15'h0, n >= ROMC_WAKE_STD_CYC - 4}, 16'h1); // Standard latency
		chk_mode(ROMC_ACTIVE);
		cmd(ROMC_CMD_IDLE, ROMC_RSP_OK);
		chk_mode(ROMC_IDLE);
		cmd(ROMC_CMD_LAT_LOW, ROMC_RSP_OK);
		check({15'h0, idle_low_latency}, 16'h1);
		cmd(ROMC_CMD_ACTIVATE, ROMC_RSP_OK);
		cmd(ROMC_CMD_ACTIVATE, ROMC_RSP_REFUSED); // Timer still running
		wait_mode(ROMC_ACTIVE, ROMC_WAKE_LOW_CYC + 6, n); // Low latency
		cmd(4'hf, ROMC_RSP_BADCMD);
	endtask

	task automatic s_link();
		int n;
		cmd(ROMC_CMD_START, ROMC_RSP_OK);
		check({14'h0, link_state}, {14'h0, ROMC_LINK_LISTEN});
		check({15'h0, report_valid}, 16'h0);
		wake_pin = 1'b1;
		for (n = 0; n < 6 && report_valid !== 1'b1; n++) @(negedge ref_clk);
		check({15'h0, report_valid}, 16'h1);
		cmd(ROMC_CMD_POLL, ROMC_RSP_OK); // Host collects by polling
		check({15'h0, report_valid}, 16'h0);
		cmd(ROMC_CMD_STOP, ROMC_RSP_OK);
		check({14'h0, link_state}, {14'h0, ROMC_LINK_CONFIG});
		cmd(ROMC_CMD_STOP, ROMC_RSP_OK); // Stop in config also listens
		check({14'h0, link_state}, {14'h0, ROMC_LINK_LISTEN});
		cmd(ROMC_CMD_STOP, ROMC_RSP_OK);
		wake_pin = 1'b0;
	endtask

	task automatic s_lowpower();
		int n;
		cmd(ROMC_CMD_STANDBY, ROMC_RSP_OK);
		wait_mode(ROMC_STANDBY, 5, n);
		chk_mode(ROMC_STANDBY);
		cmd_ignored(ROMC_CMD_ACTIVATE);
		gpio_in = 4'h5;
		wait_mode(ROMC_ACTIVE, 8, n); // Gpio wakes standby
		cmd(ROMC_CMD_SLEEP, ROMC_RSP_OK);
		wait_mode(ROMC_SLEEP, 5, n);
		cmd_ignored(ROMC_CMD_IDLE);
		gpio_in = 4'h0;
		repeat (10) @(negedge ref_clk);
		chk_mode(ROMC_SLEEP); // Gpio does not wake sleep
		wake_pin = 1'b1;
		wait_mode(ROMC_ACTIVE, 8, n);
		cmd(ROMC_CMD_SLEEP, ROMC_RSP_OK);
		repeat (10) @(negedge ref_clk);
		chk_mode(ROMC_SLEEP); // High level is not a second event
		wake_pin = 1'b0;
		repeat (5) @(negedge ref_clk);
		wake_pin = 1'b1;
		wait_mode(ROMC_ACTIVE, 8, n);
	endtask

	task automatic s_ext_reset();
		int n;
		external_reset_pin_n = 1'b0;
		wait_mode(ROMC_STARTUP, 6, n);
		repeat (3) @(negedge ref_clk);
		external_reset_pin_n = 1'b1;
		repeat (20) @(negedge ref_clk);
		chk_mode(ROMC_STARTUP);
		check({15'h0, idle_low_latency}, {15'h0, ROMC_LAT_LOW_RST});
		wake_pin = 1'b0;
		wait_mode(ROMC_IDLE, 10, n);
		chk_mode(ROMC_IDLE);
	endtask

	initial begin
		ref_clk              = 1'b0;
		resetn               = 1'b0;
		external_reset_pin_n = 1'b1;
		wake_pin             = 1'b1;
		gpio_in              = 4'h0;
		miscompares          = 0;
		checked              = 0;
		repeat (12) @(negedge ref_clk);
		resetn = 1'b1;
		s_startup();
		s_latency();
		s_link();
		s_lowpower();
		s_ext_reset();
		check(16'(i_romc_host_model.unsolicited), 16'h0);
		end_sim();
	end
endmodule
`default_nettype wire

// ===== src/romc_mode_ctrl.sv
// Operating-mode controller top: mode sequencing and host link states
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Four modes plus startup; changes from host commands, pins and reset.
// - Any reset or power-up enters startup running the bootstrap loader.
// - Startup holds while the wake pin stays high.
// - Wake pin low in startup moves the device to Idle.
// - Tag reading only in Active; suppressed elsewhere.
// - Host commands serviced only in Active and Idle.
// - Idle returns quickly to Active and resumes reading.
// - Standby wakes to Active on a gpio or wake pin event.
// - Sleep wakes to Active only on a wake pin event.
// - Idle has low-latency and standard-latency settings.
// - External reset pin resets the device through normal startup.
// - Configuration state pairs every host command with one response.
// - Start or stop command in configuration state moves the link into listen state.
module romc_mode_ctrl #(
	parameter int GPIO_W = romc_pkg::ROMC_GPIO_W,
	parameter int CNT_W  = romc_pkg::ROMC_CNT_W
) (
	input  wire logic              ref_clk,            // 20 MHz module clock
	input  wire logic              resetn,             // Power-up reset, active low
	input  wire logic              external_reset_pin_n, // Pin reset, active low
	input  wire logic              wake_pin,           // Wake pin, raw
	input  wire logic [GPIO_W-1:0] gpio_in,            // General inputs, raw
	input  wire logic              cmd_valid,          // Host command strobe
	input  wire logic [3:0]        cmd_code,           // Host command code
	output logic                   rsp_valid,          // Response strobe
	output logic [1:0]             rsp_status,         // Response status
	output romc_pkg::romc_mode_t   mode,               // Current mode
	output romc_pkg::romc_link_t   link_state,         // Host link state
	output logic                   bootstrap_active,   // Bootstrap running
	output logic                   read_enable,        // Tag reading allowed
	output logic                   host_if_enable,     // Command port open
	output logic                   idle_low_latency,   // Idle latency setting
	output logic                   report_valid        // Tag report to poll
);
	import romc_pkg::*;

	// Pin reset goes through two flops, then merges with the system reset
	logic pin_meta_r;
	logic pin_rst_r;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pin_meta_r <= 1'b1;
			pin_rst_r  <= 1'b1;
		end else begin
			pin_meta_r <= external_reset_pin_n;
			pin_rst_r  <= pin_meta_r;
		end
	end
	wire rst_n = resetn & pin_rst_r;

	romc_sync_if #(.GPIO_W(GPIO_W)) sync_bus ();

	romc_pin_sync #(.GPIO_W(GPIO_W)) i_romc_pin_sync (
		.ref_clk  (ref_clk),
		.resetn   (rst_n),
		.wake_pin (wake_pin),
		.gpio_in  (gpio_in),
		.sync     (sync_bus.src)
	);

	romc_mode_t mode_r, mode_nxt;
	romc_link_t link_r, link_nxt;
	logic       lat_low_r, lat_low_nxt;
	logic       rsp_valid_r;
	logic [1:0] rsp_status_r, rsp_status_nxt;
	logic       report_r;

	wire in_service = (mode_r == ROMC_ACTIVE) || (mode_r == ROMC_IDLE);
	wire cmd_take   = cmd_valid && in_service;
	wire cmd_known  = (cmd_code <= ROMC_CMD_POLL);
	wire cmd_act    = cmd_take && (cmd_code == ROMC_CMD_ACTIVATE);
	wire tmr_busy;
	wire tmr_done;
	wire tmr_start  = (mode_r == ROMC_IDLE) && cmd_act && !tmr_busy;
	wire [CNT_W-1:0] tmr_load = lat_low_r ? CNT_W'(ROMC_WAKE_LOW_CYC)
	                                      : CNT_W'(ROMC_WAKE_STD_CYC);

	romc_wake_timer #(.CNT_W(CNT_W)) i_romc_wake_timer (
		.ref_clk (ref_clk),
		.resetn  (rst_n),
		.start   (tmr_start),
		.load    (tmr_load),
		.busy    (tmr_busy),
		.done    (tmr_done)
	);

	// Mode sequencing
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			ROMC_STARTUP: begin
				if (!sync_bus.wake_lvl)
					mode_nxt = ROMC_IDLE;
			end
			ROMC_IDLE: begin
				if (tmr_done)
					mode_nxt = ROMC_ACTIVE;
				else if (cmd_take && cmd_code == ROMC_CMD_STANDBY)
					mode_nxt = ROMC_STANDBY;
				else if (cmd_take && cmd_code == ROMC_CMD_SLEEP)
					mode_nxt = ROMC_SLEEP;
			end
			ROMC_ACTIVE: begin
				if (cmd_take && cmd_code == ROMC_CMD_IDLE)
					mode_nxt = ROMC_IDLE;
				else if (cmd_take && cmd_code == ROMC_CMD_STANDBY)
					mode_nxt = ROMC_STANDBY;
				else if (cmd_take && cmd_code == ROMC_CMD_SLEEP)
					mode_nxt = ROMC_SLEEP;
			end
			ROMC_STANDBY: begin
				if (sync_bus.wake_rise || sync_bus.gpio_event)
					mode_nxt = ROMC_ACTIVE;
			end
			ROMC_SLEEP: begin
				if (sync_bus.wake_rise)
					mode_nxt = ROMC_ACTIVE;
			end
			default: mode_nxt = ROMC_STARTUP;
		endcase
	end

	// Link state and latency setting
	always_comb begin
		link_nxt    = link_r;
		lat_low_nxt = lat_low_r;
		if (cmd_take && link_r == ROMC_LINK_CONFIG &&
		    (cmd_code == ROMC_CMD_START || cmd_code == ROMC_CMD_STOP))
			link_nxt = ROMC_LINK_LISTEN;
		else if (cmd_take && link_r == ROMC_LINK_LISTEN && cmd_code == ROMC_CMD_STOP)
			link_nxt = ROMC_LINK_CONFIG;
		if (cmd_take && cmd_code == ROMC_CMD_LAT_LOW)
			lat_low_nxt = 1'b1;
		else if (cmd_take && cmd_code == ROMC_CMD_LAT_STD)
			lat_low_nxt = 1'b0;
	end

	// Every accepted command gets exactly one response next cycle
	always_comb begin
		if (!cmd_known)
			rsp_status_nxt = ROMC_RSP_BADCMD;
		else if (cmd_code == ROMC_CMD_ACTIVATE && mode_r == ROMC_IDLE && tmr_busy)
			rsp_status_nxt = ROMC_RSP_REFUSED;
		else
			rsp_status_nxt = ROMC_RSP_OK;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_r       <= ROMC_STARTUP;
			link_r       <= ROMC_LINK_CONFIG;
			lat_low_r    <= ROMC_LAT_LOW_RST;
			rsp_valid_r  <= 1'b0;
			rsp_status_r <= ROMC_RSP_OK;
		end else begin
			mode_r       <= mode_nxt;
			link_r       <= link_nxt;
			lat_low_r    <= lat_low_nxt;
			rsp_valid_r  <= cmd_take;
			rsp_status_r <= cmd_take ? rsp_status_nxt : rsp_status_r;
		end
	end

	// Report flag: set by a wake edge in Active listen, cleared by a poll; set wins
	wire report_set = (mode_r == ROMC_ACTIVE) && (link_r == ROMC_LINK_LISTEN) && sync_bus.wake_rise;
	wire report_clr = cmd_take && cmd_code == ROMC_CMD_POLL;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			report_r <= 1'b0;
		end else begin
			report_r <= report_set | (report_r & ~report_clr);
		end
	end

	// Registered outputs
	logic out_boot_r, out_read_r, out_host_r;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_boot_r <= 1'b1;
			out_read_r <= 1'b0;
			out_host_r <= 1'b0;
		end else begin
			out_boot_r <= (mode_nxt == ROMC_STARTUP);
			out_read_r <= (mode_nxt == ROMC_ACTIVE);
			out_host_r <= (mode_nxt == ROMC_ACTIVE) || (mode_nxt == ROMC_IDLE);
		end
	end

	assign mode             = mode_r;
	assign link_state       = link_r;
	assign bootstrap_active = out_boot_r;
	assign read_enable      = out_read_r;
	assign host_if_enable   = out_host_r;
	assign idle_low_latency = lat_low_r;
	assign rsp_valid        = rsp_valid_r;
	assign rsp_status       = rsp_status_r;
	assign report_valid     = report_r;

	// Cycles since the wake timer started, and the setting it started with
	localparam int WAKE_STD_MAX = ROMC_WAKE_STD_CYC + 2;
	localparam int WAKE_LOW_MAX = ROMC_WAKE_LOW_CYC + 2;
	logic [CNT_W-1:0] wake_age_r;
	logic             wake_lat_r;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wake_age_r <= '0;
			wake_lat_r <= 1'b0;
		end else if (tmr_start) begin
			wake_age_r <= CNT_W'(1);
			wake_lat_r <= lat_low_r;
		end else if (wake_age_r != '1) begin
			wake_age_r <= wake_age_r + CNT_W'(1);
		end
	end
	// Timer load plus one edge for the done pulse and one for the mode register
	wire [CNT_W-1:0] wake_age_exp = wake_lat_r ? CNT_W'(ROMC_WAKE_LOW_CYC + 2)
	                                           : CNT_W'(ROMC_WAKE_STD_CYC + 2);

	a_read_only_active: assert property (@(posedge ref_clk) disable iff (!rst_n)
		read_enable |-> mode == ROMC_ACTIVE)
		else $error("reading outside Active");
	a_read_when_active: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_ACTIVE |-> read_enable)
		else $error("Active without reading enabled");
	a_no_rsp_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_valid && (mode == ROMC_STANDBY || mode == ROMC_SLEEP) |=> !rsp_valid)
		else $error("command answered in low power mode");
	a_host_if_modes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		host_if_enable == (mode == ROMC_ACTIVE || mode == ROMC_IDLE))
		else $error("command port enable disagrees with mode");
	a_cmd_port_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rsp_valid |-> $past(host_if_enable))
		else $error("response while command port closed");
	a_rsp_paired: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rsp_valid == $past(cmd_take))
		else $error("response not paired with command");
	a_badcmd_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_take && cmd_code > ROMC_CMD_POLL |=> rsp_status == ROMC_RSP_BADCMD)
		else $error("unknown command not answered as bad");
	a_refused_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_act && mode == ROMC_IDLE && tmr_busy |=> rsp_status == ROMC_RSP_REFUSED)
		else $error("activate during wake wait not refused");
	a_boot_in_startup: assert property (@(posedge ref_clk) disable iff (!rst_n)
		bootstrap_active == (mode == ROMC_STARTUP))
		else $error("bootstrap flag disagrees with mode");
	a_startup_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_STARTUP && sync_bus.wake_lvl |=> mode == ROMC_STARTUP)
		else $error("startup left with wake high");
	a_startup_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_STARTUP && !sync_bus.wake_lvl |=> mode == ROMC_IDLE)
		else $error("startup not left for Idle");
	a_startup_to_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_STARTUP |=> mode == ROMC_STARTUP || mode == ROMC_IDLE)
		else $error("startup left for a mode other than Idle");
	a_active_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_ACTIVE && $past(mode) != ROMC_ACTIVE |-> $past(mode) != ROMC_STARTUP)
		else $error("Active entered straight from startup");
	a_idle_to_active: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_ACTIVE && $past(mode) == ROMC_IDLE |-> $past(tmr_done))
		else $error("Idle left for Active without wake timer");
	a_idle_wake_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tmr_start && !lat_low_r |-> ##[1:WAKE_STD_MAX] tmr_done)
		else $error("standard wake timer too slow");
	a_idle_wake_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tmr_start && lat_low_r |-> ##[1:WAKE_LOW_MAX] tmr_done)
		else $error("low latency wake timer too slow");
	a_wake_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_ACTIVE && $past(mode) == ROMC_IDLE |-> wake_age_r == wake_age_exp)
		else $error("Idle to Active latency wrong for setting");
	a_standby_wakes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_STANDBY && (sync_bus.gpio_event || sync_bus.wake_rise) |=> mode == ROMC_ACTIVE)
		else $error("Standby missed wake event");
	a_standby_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_STANDBY && !sync_bus.gpio_event && !sync_bus.wake_rise |=> mode == ROMC_STANDBY)
		else $error("Standby left without event");
	a_sleep_gpio_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_SLEEP && !sync_bus.wake_rise |=> mode == ROMC_SLEEP)
		else $error("Sleep left without wake edge");
	a_sleep_wakes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode == ROMC_SLEEP && sync_bus.wake_rise |=> mode == ROMC_ACTIVE)
		else $error("Sleep missed wake edge");
	a_listen_on_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_take && link_r == ROMC_LINK_CONFIG && cmd_code == ROMC_CMD_START |=> link_state == ROMC_LINK_LISTEN)
		else $error("start did not enter listen");
	a_listen_on_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_take && link_r == ROMC_LINK_CONFIG && cmd_code == ROMC_CMD_STOP |=> link_state == ROMC_LINK_LISTEN)
		else $error("stop in config did not enter listen");
	a_config_on_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_take && link_r == ROMC_LINK_LISTEN && cmd_code == ROMC_CMD_STOP |=> link_state == ROMC_LINK_CONFIG)
		else $error("stop in listen did not return to config");
	a_link_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cmd_take |=> $stable(link_state))
		else $error("link state moved without a command");
	a_lat_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cmd_take |=> $stable(idle_low_latency))
		else $error("latency setting moved without a command");
	a_lat_low_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_take && cmd_code == ROMC_CMD_LAT_LOW |=> idle_low_latency)
		else $error("low latency not selected");
	a_lat_std_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd_take && cmd_code == ROMC_CMD_LAT_STD |=> !idle_low_latency)
		else $error("standard latency not selected");
	a_report_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		report_set |=> report_valid)
		else $error("tag report not flagged");
	a_report_poll: assert property (@(posedge ref_clk) disable iff (!rst_n)
		report_clr && !report_set |=> !report_valid)
		else $error("poll did not collect the report");
	a_reset_startup: assert property (@(posedge ref_clk)
		!rst_n |=> mode == ROMC_STARTUP)
		else $error("reset did not enter startup");
endmodule
`default_nettype wire

// ===== src/romc_pin_sync.sv
// Two-stage pin synchronisers with wake and gpio edge detect
`timescale 1ns/1ps
`default_nettype none
module romc_pin_sync #(
	parameter int GPIO_W = 4
) (
	input  wire logic              ref_clk,  // Module clock
	input  wire logic              resetn,   // Sync reset, active low
	input  wire logic              wake_pin, // Raw wake pin
	input  wire logic [GPIO_W-1:0] gpio_in,  // Raw general inputs
	romc_sync_if.src               sync      // Synchronised outputs
);
	logic [GPIO_W:0] meta_r;
	logic [GPIO_W:0] stab_r;
	logic [GPIO_W:0] prev_r;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			// Wake reads high until really sampled, so startup never sees a false low
			meta_r <= {1'b1, {GPIO_W{1'b0}}};
			stab_r <= {1'b1, {GPIO_W{1'b0}}};
			prev_r <= {1'b1, {GPIO_W{1'b0}}};
		end else begin
			meta_r <= {wake_pin, gpio_in};
			stab_r <= meta_r;
			prev_r <= stab_r;
		end
	end

	assign sync.wake_lvl   = stab_r[GPIO_W];
	assign sync.wake_rise  = stab_r[GPIO_W] & ~prev_r[GPIO_W];
	assign sync.gpio_event = |(stab_r[GPIO_W-1:0] ^ prev_r[GPIO_W-1:0]);
	assign sync.gpio_lvl   = stab_r[GPIO_W-1:0];

	a_wake_rise_single: assert property (@(posedge ref_clk) disable iff (!resetn)
		sync.wake_rise |=> !sync.wake_rise)
		else $error("wake edge longer than one cycle");
endmodule
`default_nettype wire

// ===== src/romc_pkg.sv
// Shared constants and types for the reader operating-mode controller
package romc_pkg;
	typedef enum logic [2:0] {
		ROMC_STARTUP,
		ROMC_ACTIVE,
		ROMC_IDLE,
		ROMC_STANDBY,
		ROMC_SLEEP
	} romc_mode_t;

	typedef enum logic [1:0] {
		ROMC_LINK_CONFIG,
		ROMC_LINK_LISTEN
	} romc_link_t;

	// Host command codes
	localparam logic [3:0] ROMC_CMD_NOP      = 4'h0;
	localparam logic [3:0] ROMC_CMD_ACTIVATE = 4'h1;
	localparam logic [3:0] ROMC_CMD_IDLE     = 4'h2;
	localparam logic [3:0] ROMC_CMD_STANDBY  = 4'h3;
	localparam logic [3:0] ROMC_CMD_SLEEP    = 4'h4;
	localparam logic [3:0] ROMC_CMD_START    = 4'h5;
	localparam logic [3:0] ROMC_CMD_STOP     = 4'h6;
	localparam logic [3:0] ROMC_CMD_LAT_LOW  = 4'h7;
	localparam logic [3:0] ROMC_CMD_LAT_STD  = 4'h8;
	localparam logic [3:0] ROMC_CMD_POLL     = 4'h9;

	// Response status codes
	localparam logic [1:0] ROMC_RSP_OK      = 2'h0;
	localparam logic [1:0] ROMC_RSP_BADCMD  = 2'h1;
	localparam logic [1:0] ROMC_RSP_REFUSED = 2'h2;

	// Clock and wake latency
	localparam int ROMC_CLK_HZ          = 20_000_000;
	localparam int ROMC_WAKE_LOW_NS     = 1000;
	localparam int ROMC_WAKE_STD_NS     = 10000;
	localparam int ROMC_WAKE_LOW_CYC    = (ROMC_WAKE_LOW_NS * (ROMC_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int ROMC_WAKE_STD_CYC    = (ROMC_WAKE_STD_NS * (ROMC_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int ROMC_CNT_W           = 16;
	localparam int ROMC_GPIO_W          = 4;
	localparam logic                    ROMC_LAT_LOW_RST = 1'b0;
endpackage

// ===== src/romc_sync_if.sv
// Interface carrying synchronised pin levels and wake edges
`timescale 1ns/1ps
`default_nettype none
interface romc_sync_if #(parameter int GPIO_W = 4);
	logic              wake_lvl;
	logic              wake_rise;
	logic              gpio_event;
	logic [GPIO_W-1:0] gpio_lvl;
	modport src (output wake_lvl, output wake_rise, output gpio_event, output gpio_lvl);
	modport dst (input wake_lvl, input wake_rise, input gpio_event, input gpio_lvl);
endinterface
`default_nettype wire

// ===== src/romc_wake_timer.sv
// Wake latency counter for the return from Idle to Active
`timescale 1ns/1ps
`default_nettype none
module romc_wake_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic             ref_clk, // Module clock
	input  wire logic             resetn,  // Sync reset, active low
	input  wire logic             start,   // Load count, one pulse
	input  wire logic [CNT_W-1:0] load,    // Cycles to wait
	output logic                  busy,    // Counting
	output logic                  done     // Expiry pulse
);
	logic [CNT_W-1:0] cnt_r;
	logic             busy_r;
	logic             done_r;
	wire              last = busy_r && (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1});

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= last;
			if (start) begin
				cnt_r  <= load;
				busy_r <= 1'b1;
			end else if (last) begin
				cnt_r  <= '0;
				busy_r <= 1'b0;
			end else if (busy_r) begin
				cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign busy = busy_r;
	assign done = done_r;
endmodule
`default_nettype wire
